//--- pkg/aiag_pkg.sv
// Package for the adaptive input aligner and its input gearbox.
// Assumes one 125 MHz capture clock; the fabric clock is derived inside the block.
package aiag_pkg;

    // Capture clock period in picoseconds.
    localparam int CLK_PERIOD_PS = 8000;
    // Delay chain length; one bit period spans the whole chain at single rate.
    localparam int NTAPS = 8;
    localparam int TAP_W = 3;
    // Taps per bit period at single and double rate.
    localparam logic [3:0] UI_SDR = 4'h8;
    localparam logic [3:0] UI_DDR = 4'h4;
    // Capture cycles over which transitions are gathered before a decision.
    localparam logic [7:0] EVAL_CYCLES = 8'h40;
    // Bits per fabric word in the two gearbox ratios.
    localparam logic [2:0] GEAR_X2_BITS = 3'h2;
    localparam logic [2:0] GEAR_X4_BITS = 3'h4;
    // Values after reset.
    localparam logic [TAP_W-1:0] TAP_RST = 3'h0;
    localparam logic [3:0] WORD_RST = 4'h0;

    // User controls of the cell.
    typedef struct packed {
        logic rate_ddr;
        logic gear_x4;
        logic [2:0] win_width;
        logic freeze;
        logic [TAP_W-1:0] freeze_tap;
    } aiag_ctl_t;

    // Aligner state shown to user logic.
    typedef struct packed {
        logic [TAP_W-1:0] tap;
        logic locked;
    } aiag_stat_t;

    // Deserialised word handed to the fabric.
    typedef struct packed {
        logic [3:0] word;
        logic word_valid;
        logic ls_clk;
    } aiag_word_t;

    // Aligner activity.
    typedef enum logic [1:0] {
        AIAG_SEARCH = 2'b00,
        AIAG_TRACK = 2'b01,
        AIAG_HOLD = 2'b10
    } aiag_state_t;

endpackage

//--- src/aiag_align_gearbox.sv
// Adaptive input aligner with input DDR/shift gearbox for one programmable_io_cell.
// Assumes serial data arrives synchronous to clk, one chain sample per clock.
//
// What this block does
// - Incoming data runs through a tapped delay chain giving several delayed copies.
// - Pick a tap where data is stable, away from transitions, to sample.
// - After lock, keep watching and step the tap as the data phase drifts.
// - Slide a window along the chain, judging stability only from seen transitions.
// - Align on any traffic with transitions; no training sequence is needed.
// - Window width is a user setting, covering the full data rate range.
// - A dynamic control either keeps tracking edges or freezes at a chosen tap.
// - Both single rate and double rate capture are supported.
// - The aligner exists only on the first and third cells of edge groups.
// - Every cell offers double rate capture and a two-bit deserialiser.
// - One cell with gear_x4 set forms a four-bit deserialiser on its own.
// - Capture on the fast clock and hand words into the slow fabric domain.
// - Shift, update and divider stages do the crossing with no user logic.
`timescale 1ns/1ps
`default_nettype none

module aiag_align_gearbox #(
    // Set to 0 on cells that carry no aligner; the tap then stays fixed.
    parameter bit HAS_ALIGNER = 1'b1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Serial input data.
    input wire logic din,
    // User controls.
    input wire aiag_pkg::aiag_ctl_t ctl,
    // Aligner status.
    output var aiag_pkg::aiag_stat_t stat,
    // Fabric side word.
    output var aiag_pkg::aiag_word_t wout
);
    import aiag_pkg::*;

    // Fold a chain position into one bit period.
    function automatic logic [TAP_W-1:0] fold(input logic [TAP_W-1:0] p, input logic ddr);
        fold = ddr ? {1'b0, p[1:0]} : p;
    endfunction

    // Test whether a window of width w starting at p sees no transition.
    function automatic logic win_clean(input logic [NTAPS-1:0] map, input logic [TAP_W-1:0] p,
                                       input logic [2:0] w, input logic ddr);
        logic ok;
        logic [TAP_W-1:0] idx;
        ok = 1'b1;
        idx = p;
        for (int k = 0; k < NTAPS; k++) begin
            idx = fold(p + k[TAP_W-1:0], ddr);
            if (k[2:0] <= w && map[idx]) begin
                ok = 1'b0;
            end
        end
        win_clean = ok;
    endfunction

    logic [NTAPS-1:0] chain_reg;
    logic [TAP_W-1:0] phase_reg;
    logic [NTAPS-1:0] edge_map_reg;
    logic [7:0] eval_cnt_reg;
    logic eval_done;
    logic [TAP_W-1:0] tap_reg;
    logic [TAP_W-1:0] tap_next;
    logic locked_reg;
    logic locked_next;
    aiag_state_t state_reg;
    aiag_state_t state_next;
    logic found;
    logic [TAP_W-1:0] best_center;
    logic [TAP_W-1:0] half_w;
    logic bit_strobe;
    logic sample_bit;
    logic [3:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [2:0] word_bits;
    logic [3:0] word_reg;
    logic valid_reg;
    logic ls_clk_reg;

    // The chain holds the last NTAPS samples; each tap is a delayed copy of the stream.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= {chain_reg[NTAPS-2:0], din};
        end
    end

    // Free running phase of the sampling instant within the chain.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_reg + 3'h1;
        end
    end

    // Transitions are binned by the tap they would sit on at the sampling instant.
    // Only edges are recorded, never data values, so any traffic with edges works.
    // An edge on the decision cycle opens the next map, so the set wins over the clear.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            edge_map_reg <= '0;
        end else begin
            if (eval_done) begin
                edge_map_reg <= '0;
            end
            if (din != chain_reg[0]) begin
                edge_map_reg[fold(~phase_reg, ctl.rate_ddr)] <= 1'b1;
            end
        end
    end

    // Gathering interval counter; a decision is taken on its last cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eval_cnt_reg <= '0;
        end else begin
            eval_cnt_reg <= eval_done ? 8'h00 : eval_cnt_reg + 8'h01;
        end
    end

    assign eval_done = (eval_cnt_reg == EVAL_CYCLES - 8'h01);
    assign half_w = {1'b0, ctl.win_width[2:1]};

    // Slide the window over every start tap, only taps 0 to 3 at double rate; keep the lowest clean one.
    always_comb begin
        found = 1'b0;
        best_center = tap_reg;
        for (int p = NTAPS - 1; p >= 0; p--) begin
            if ((!ctl.rate_ddr || p < 4) &&
                win_clean(edge_map_reg, p[TAP_W-1:0], ctl.win_width, ctl.rate_ddr)) begin
                found = 1'b1;
                best_center = fold(p[TAP_W-1:0] + half_w, ctl.rate_ddr);
            end
        end
    end

    // Decide the tap at the end of each gathering interval.
    always_comb begin
        // Folding every cycle keeps the tap inside one bit period after a rate change.
        tap_next = fold(tap_reg, ctl.rate_ddr);
        locked_next = locked_reg;
        state_next = state_reg;
        if (!HAS_ALIGNER) begin
            tap_next = TAP_RST;
            locked_next = 1'b0;
            state_next = AIAG_HOLD;
        end else if (ctl.freeze) begin
            tap_next = fold(ctl.freeze_tap, ctl.rate_ddr);
            state_next = AIAG_HOLD;
        end else if (eval_done && edge_map_reg != '0) begin
            // An interval with no edges says nothing, so the decision is skipped.
            unique case (state_reg)
                AIAG_SEARCH, AIAG_HOLD: begin
                    if (found) begin
                        tap_next = best_center;
                        locked_next = 1'b1;
                        state_next = AIAG_TRACK;
                    end
                end
                AIAG_TRACK: begin
                    // Step one tap at a time so the sample never jumps across an eye.
                    if (!found) begin
                        locked_next = 1'b0;
                        state_next = AIAG_SEARCH;
                    end else if (best_center != tap_reg) begin
                        if (fold(best_center - tap_reg, ctl.rate_ddr) <
                            fold(tap_reg - best_center, ctl.rate_ddr)) begin
                            tap_next = fold(tap_reg + 3'h1, ctl.rate_ddr);
                        end else begin
                            tap_next = fold(tap_reg - 3'h1, ctl.rate_ddr);
                        end
                    end
                end
            endcase
        end
    end

    // Aligner state registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tap_reg <= TAP_RST;
            locked_reg <= 1'b0;
            state_reg <= AIAG_SEARCH;
        end else begin
            tap_reg <= tap_next;
            locked_reg <= locked_next;
            state_reg <= state_next;
        end
    end

    // Sample the chosen tap once per bit; at double rate twice per chain length.
    assign bit_strobe = (fold(phase_reg, ctl.rate_ddr) == 3'h0);
    assign sample_bit = chain_reg[tap_reg];
    assign word_bits = ctl.gear_x4 ? GEAR_X4_BITS : GEAR_X2_BITS;

    // Shift stage on the fast clock.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_reg <= WORD_RST;
            bit_cnt_reg <= '0;
        end else if (bit_strobe) begin
            shift_reg <= {shift_reg[2:0], sample_bit};
            bit_cnt_reg <= (bit_cnt_reg + 3'h1 >= word_bits) ? 3'h0 : bit_cnt_reg + 3'h1;
        end
    end

    // Update stage: a whole word is moved at once so the fabric never sees a partial one.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word_reg <= WORD_RST;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= 1'b0;
            if (bit_strobe && (bit_cnt_reg + 3'h1 >= word_bits)) begin
                word_reg <= ctl.gear_x4 ? {shift_reg[2:0], sample_bit}
                                        : {2'b00, shift_reg[0], sample_bit};
                valid_reg <= 1'b1;
            end
        end
    end

    // Divided fabric clock: high for the first half of each word period.
    // The word changes at its rising edge, giving the fabric a full period to take it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ls_clk_reg <= 1'b0;
        end else if (bit_strobe) begin
            ls_clk_reg <= (bit_cnt_reg + 3'h1 >= word_bits) ||
                          (ctl.gear_x4 && bit_cnt_reg == 3'h0);
        end
    end

    // Lanes are aligned one by one; bus deskew is left to fabric logic.
    assign stat.tap = tap_reg;
    assign stat.locked = locked_reg;
    assign wout.word = word_reg;
    assign wout.word_valid = valid_reg;
    assign wout.ls_clk = ls_clk_reg;

    // Checks on the aligner and gearbox.
    AST_TAP_IN_PERIOD: assert property (@(posedge clk) disable iff (!rstn)
        ctl.rate_ddr |-> tap_reg < 3'h4 || $changed(ctl.rate_ddr) || $past(!ctl.rate_ddr))
        else $error("Tap outside the double rate bit period.");

    AST_FREEZE_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
        HAS_ALIGNER && ctl.freeze |=> tap_reg == fold($past(ctl.freeze_tap), $past(ctl.rate_ddr)))
        else $error("Frozen aligner did not sit at the chosen tap.");

    AST_TRACK_ONE_STEP: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == AIAG_TRACK && !ctl.freeze && !ctl.rate_ddr && $stable(ctl.rate_ddr)
        |=> (tap_reg - $past(tap_reg)) inside {3'h0, 3'h1, 3'h7})
        else $error("Tracking moved the tap by more than one.");

    AST_NO_ALIGNER_FIXED: assert property (@(posedge clk) disable iff (!rstn)
        !HAS_ALIGNER |=> tap_reg == TAP_RST && !locked_reg)
        else $error("Cell without aligner moved its tap.");

    AST_LOCK_ON_CLEAN: assert property (@(posedge clk) disable iff (!rstn)
        $rose(locked_reg) |-> $past(eval_done) && $past(found) && $past(edge_map_reg != '0))
        else $error("Lock taken without a clean window.");

    AST_SHIFT_TAKES_TAP: assert property (@(posedge clk) disable iff (!rstn)
        bit_strobe |=> shift_reg[0] == $past(chain_reg[tap_reg]))
        else $error("Shift stage did not take the selected tap.");

    AST_DDR_STROBE: assert property (@(posedge clk) disable iff (!rstn)
        bit_strobe && ctl.rate_ddr ##1 ctl.rate_ddr [*4] |-> bit_strobe)
        else $error("Double rate strobe not every four cycles.");

    AST_VALID_PULSE: assert property (@(posedge clk) disable iff (!rstn)
        valid_reg |=> !valid_reg [*3])
        else $error("Word valid repeated too soon.");

    AST_X4_WORD: assert property (@(posedge clk) disable iff (!rstn)
        bit_strobe && ctl.gear_x4 && bit_cnt_reg == 3'h3 && $stable(ctl.gear_x4)
        |=> valid_reg && word_reg == {$past(shift_reg[2:0]), $past(sample_bit)})
        else $error("Four-bit word not assembled from the shift stage.");

    AST_EDGE_KEPT: assert property (@(posedge clk) disable iff (!rstn)
        din != chain_reg[0] |=> edge_map_reg[$past(fold(~phase_reg, ctl.rate_ddr))])
        else $error("Observed transition missing from the edge map.");

    AST_TAP_STANDS: assert property (@(posedge clk) disable iff (!rstn)
        HAS_ALIGNER && !ctl.freeze && !eval_done && $stable(ctl.rate_ddr) |=> $stable(tap_reg))
        else $error("Tap moved outside a decision.");

    AST_LOCK_DROPS: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == AIAG_TRACK && !ctl.freeze && eval_done && edge_map_reg != '0 && !found
        |=> !locked_reg && state_reg == AIAG_SEARCH)
        else $error("Lock kept although no clean window remained.");

    COV_LOCK: cover property (@(posedge clk) disable iff (!rstn) $rose(locked_reg));
    COV_STEP: cover property (@(posedge clk) disable iff (!rstn)
        state_reg == AIAG_TRACK && $changed(tap_reg));
    COV_FREEZE: cover property (@(posedge clk) disable iff (!rstn) ctl.freeze && valid_reg);
    COV_X4_DDR: cover property (@(posedge clk) disable iff (!rstn)
        ctl.gear_x4 && ctl.rate_ddr && valid_reg);

endmodule

`default_nettype wire

//--- dv/aiag_tx_model.sv
// Behavioural transmitter that drives serial data into the aligner cell.
// Assumes the bench sets the bit period in samples, a launch phase below it and a pattern.
`timescale 1ns/1ps
`default_nettype none

module aiag_tx_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Bit period in samples, launch phase and the bits to send.
    input wire logic [3:0] ui,
    input wire logic [3:0] phase,
    input wire logic [15:0] pattern,
    // Serial data towards the cell.
    output logic din
);
    logic [3:0] cnt_reg;
    logic [3:0] idx_reg;

    // One lane only; deskewing several lanes of a bus is left to fabric logic.

    // Each bit is held for a whole period; moving the phase stretches one bit, which is how drift is made.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 4'h0;
            idx_reg <= 4'h0;
            din <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg == ui - 4'h1) ? 4'h0 : cnt_reg + 4'h1;
            if (cnt_reg == phase) begin
                din <= pattern[idx_reg];
                idx_reg <= idx_reg + 4'h1;
            end
        end
    end
endmodule

`default_nettype wire

//--- dv/aiag_align_gearbox_tb.sv
// Self-checking bench for the aligner and gearbox of one cell.
// Assumes a single 125 MHz clock; expected words are queued and checked as they appear.
`timescale 1ns/1ps
`default_nettype none

module aiag_align_gearbox_tb;
    import aiag_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic din;
    aiag_ctl_t ctl = '0;
    aiag_stat_t stat;
    aiag_stat_t stat_fixed;
    aiag_word_t wout;
    logic [3:0] ui = 4'h8;
    logic [3:0] phase = 4'h0;
    logic [15:0] pattern = 16'hFFFF;
    logic [31:0] seed = 32'h000128DB;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [3:0] exp_q[$];
    int exp_gap = 0;
    int gap = 0;
    logic track = 1'b0;
    logic [2:0] last_tap = 3'h0;
    logic [2:0] tap0;

    // Free running capture clock.
    always #4 clk = ~clk;

    aiag_align_gearbox #(.HAS_ALIGNER(1'b1)) i_aiag_align_gearbox (
        .clk(clk), .rstn(rstn), .din(din), .ctl(ctl), .stat(stat), .wout(wout));
    // A cell without an aligner sees the same stream; its tap must never move.
    aiag_align_gearbox #(.HAS_ALIGNER(1'b0)) i_aiag_align_gearbox_fixed (
        .clk(clk), .rstn(rstn), .din(din), .ctl(ctl), .stat(stat_fixed), .wout());
    aiag_tx_model i_aiag_tx_model (
        .clk(clk), .rstn(rstn), .ui(ui), .phase(phase), .pattern(pattern), .din(din));

    // Fibonacci style step; a fixed start keeps every run the same.
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t mismatch on %s", $time, what);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        wait_cycles(5);
        check(stat === '0 && wout === '0, "reset values");
        rstn <= 1'b1;
        wait_cycles(1);
    endtask

    // Waits for one word strobe, bounded so a silent gearbox is caught.
    task automatic wait_word();
        int i;
        i = 0;
        // Looked at on falling edges, where the registered strobe has settled.
        @(negedge clk);
        while (wout.word_valid !== 1'b1 && i < 100) begin
            @(negedge clk);
            i++;
        end
        check(i < 100, "word strobe");
        @(posedge clk);
    endtask

    // Steady input so every word is known; the first words after a change are flushed.
    task automatic run_words(input logic ddr, input logic x4);
        int i;
        ctl.rate_ddr <= ddr;
        ctl.gear_x4 <= x4;
        pattern <= 16'hFFFF;
        exp_q.delete();
        repeat (3) wait_word();
        exp_gap = (ddr ? 4 : 8) * (x4 ? 4 : 2);
        repeat (4) exp_q.push_back(x4 ? 4'hF : 4'h3);
        i = 0;
        while (exp_q.size() > 0 && i < 400) begin
            @(posedge clk);
            i++;
        end
        check(exp_q.size() == 0, "words delivered");
        $display("test words ddr=%0b x4=%0b done", ddr, x4);
    endtask

    // Watches strobes and tap moves; spacing is judged only while words are expected.
    // Sampled on the falling edge so that registered outputs have settled.
    always @(negedge clk) begin
        if (rstn === 1'b1 && wout.word_valid === 1'b1) begin
            if (exp_q.size() > 0) begin
                check(wout.word === exp_q.pop_front(), "word value");
                check(gap == exp_gap, "word spacing");
                check(wout.ls_clk === 1'b1, "fabric clock high with new word");
            end
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
        if (track && stat.tap !== last_tap) begin
            check(stat.tap - last_tap == 3'h1 || last_tap - stat.tap == 3'h1, "tap step");
        end
        last_tap <= stat.tap;
    end

    // Watchdog sized well above the length of the whole sequence.
    initial begin
        wait_cycles(20000);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        do_reset();
        ctl.freeze <= 1'b1;
        for (int t = 0; t < 8; t++) begin
            ctl.freeze_tap <= t[2:0];
            wait_cycles(3);
            check(stat.tap === t[2:0], "frozen tap");
        end
        ctl.rate_ddr <= 1'b1;
        ctl.freeze_tap <= 3'h6;
        wait_cycles(3);
        check(stat.tap === 3'h2, "frozen tap at double rate");
        $display("test freeze done");
        for (int m = 0; m < 4; m++) begin
            run_words(m[0], m[1]);
        end
        // Random traffic with a transition in every byte; no training pattern is sent.
        seed = lfsr(seed);
        pattern <= {seed[7:0], ~seed[7:0]};
        ctl <= '{rate_ddr: 1'b0, gear_x4: 1'b0, win_width: 3'h1, freeze: 1'b0, freeze_tap: 3'h0};
        phase <= 4'h3;
        wait_cycles(200);
        check(stat.locked === 1'b1, "lock on random data");
        tap0 = stat.tap;
        track <= 1'b1;
        for (int k = 1; k < 4; k++) begin
            phase <= 4'h3 + k[3:0];
            wait_cycles(200);
            check(stat.locked === 1'b1, "lock kept under drift");
        end
        track <= 1'b0;
        check(stat.tap !== tap0, "tap followed drift");
        check(stat_fixed === '0, "cell without aligner stays at tap zero");
        $display("test lock and drift done");
        // A window of eight clean taps cannot exist while data toggles.
        do_reset();
        ctl.win_width <= 3'h7;
        wait_cycles(200);
        check(stat.locked === 1'b0, "wide window refuses lock");
        do_reset();
        $display("test window width done");
        print_verdict();
    end
endmodule

`default_nettype wire
